/* cbr_defines.vh */
// Constants for the configurable block RAM: modes, shapes, read-during-write
// choices, bus offsets. Included by the RAM design file and the bench.
`ifndef CBR_DEFINES_VH
`define CBR_DEFINES_VH

`define CBR_MEM_BITS        9216
`define CBR_MAX_WORDS       8192
`define CBR_MAX_WIDTH       36
`define CBR_TDP_MAX_WIDTH   18
`define CBR_SR_MAX_WIDTH    36

`define CBR_MODE_SP         3'h0
`define CBR_MODE_SDP        3'h1
`define CBR_MODE_TDP        3'h2
`define CBR_MODE_SHIFT      3'h3
`define CBR_MODE_ROM        3'h4
`define CBR_MODE_FIFO       3'h5

`define CBR_CLK_INDEP       2'h0
`define CBR_CLK_INOUT       2'h1
`define CBR_CLK_RDWR        2'h2
`define CBR_CLK_SINGLE      2'h3

`define CBR_RDW_OLD         2'h0
`define CBR_RDW_NEW         2'h1
`define CBR_RDW_DONTCARE    2'h2

`define CBR_DONTCARE_WORD   36'h000000000

`define CBR_OFF_CTRL        12'h000
`define CBR_OFF_STATUS      12'h004
`define CBR_OFF_CONFIG      12'h008

`define CBR_CTRL_CLR_BIT    0
`define CBR_STAT_BUSY_BIT   0
`define CBR_STAT_CONF_BIT   1

`define CBR_RESP_OKAY       2'h0
`define CBR_RESP_SLVERR     2'h2

`endif

/* cbr_block_ram.v */
// Configurable block RAM with two access ports and an AXI4-Lite control slave.
// Assumes one clock, synchronous active-low reset, user logic driving ports.
// Undefined data (double writes, port B reads colliding with a write) is modelled as zero.
//
// How it works
// - Single-port: read or write, one address
// - Single-port write with read: new or old
// - Write without read keeps last read output
// - Single-port shapes 8192x1 up to 256x36
// - Output register adds exactly one cycle
// - Simple dual-port: one write, one read
// - Mixed widths within one width group only
// - Independent write and read strobes per port
// - Simple dual-port collision: undefined or old
// - True dual-port: both ports read or write
// - True dual-port widest shape 512x16 or 512x18
// - True dual-port mixed widths, no 32/36
// - True dual-port same port: new or old
// - Either port reaches any location anytime
// - Same-address double write stores undefined data
// - Shift size limits 9216 bits, 36 wide
// - ROM: no writes, registered address, like single-port
// - Four clocking modes are supported
// - Read/write clocks: collision gives undefined data
// - Clear hits output latches and output registers only
// - New data appears in the write cycle
// - All accesses on rising clock edges
// - Outputs read zero until first read
// - One clock, i_ref_clk, drives both ports' registers
`timescale 1ns/1ps
`include "cbr_defines.vh"

module cbr_block_ram #(
    parameter [2:0] MODE       = `CBR_MODE_TDP,
    parameter [1:0] CLK_MODE   = `CBR_CLK_SINGLE,
    parameter [1:0] RDW_SAME   = `CBR_RDW_NEW,
    parameter [1:0] RDW_MIXED  = `CBR_RDW_OLD,
    parameter       WIDTH_A    = 16,
    parameter       WIDTH_B    = 16,
    parameter       OUT_REG    = 0,
    parameter       SR_TAPS    = 1
) (
    input  wire                   i_ref_clk,
    input  wire                   i_rst_n,
    input  wire                   i_clr,
    input  wire [12:0]            i_addr_a,
    input  wire [WIDTH_A-1:0]     i_data_a,
    input  wire                   i_wr_en_a,
    input  wire                   i_rd_en_a,
    output wire [WIDTH_A-1:0]     o_q_a,
    input  wire [12:0]            i_addr_b,
    input  wire [WIDTH_B-1:0]     i_data_b,
    input  wire                   i_wr_en_b,
    input  wire                   i_rd_en_b,
    output wire [WIDTH_B-1:0]     o_q_b,
    output wire                   o_collision,
    input  wire [31:0]            s_axi_awaddr,
    input  wire                   s_axi_awvalid,
    output wire                   s_axi_awready,
    input  wire [31:0]            s_axi_wdata,
    input  wire [3:0]             s_axi_wstrb,
    input  wire                   s_axi_wvalid,
    output wire                   s_axi_wready,
    output wire [1:0]             s_axi_bresp,
    output wire                   s_axi_bvalid,
    input  wire                   s_axi_bready,
    input  wire [31:0]            s_axi_araddr,
    input  wire                   s_axi_arvalid,
    output wire                   s_axi_arready,
    output wire [31:0]            s_axi_rdata,
    output wire [1:0]             s_axi_rresp,
    output wire                   s_axi_rvalid,
    input  wire                   s_axi_rready
);

    // Geometry: storage in units of the narrower width, ports scale addresses
    localparam WN      = (WIDTH_A < WIDTH_B) ? WIDTH_A : WIDTH_B;
    localparam RA      = WIDTH_A / WN;
    localparam RB      = WIDTH_B / WN;
    localparam PARITY  = (WN == 9) || (WN == 18) || (WN == 36);
    localparam BITS    = PARITY ? `CBR_MEM_BITS : `CBR_MAX_WORDS;
    localparam DEPTH   = BITS / WN;
    localparam WA      = BITS / WIDTH_A;
    localparam WB      = BITS / WIDTH_B;
    localparam SR_LEN  = WA / SR_TAPS;

    // Static shape check: legal widths and group pairing
    localparam LEG_A = (WIDTH_A == 1) || (WIDTH_A == 2) || (WIDTH_A == 4) ||
                       (WIDTH_A == 8) || (WIDTH_A == 16) || (WIDTH_A == 32) ||
                       (WIDTH_A == 9) || (WIDTH_A == 18) || (WIDTH_A == 36);
    localparam LEG_B = (WIDTH_B == 1) || (WIDTH_B == 2) || (WIDTH_B == 4) ||
                       (WIDTH_B == 8) || (WIDTH_B == 16) || (WIDTH_B == 32) ||
                       (WIDTH_B == 9) || (WIDTH_B == 18) || (WIDTH_B == 36);
    localparam G_A = (WIDTH_A == 9 || WIDTH_A == 18 || WIDTH_A == 36);
    localparam G_B = (WIDTH_B == 9 || WIDTH_B == 18 || WIDTH_B == 36);
    localparam TDP_WIDE = (MODE == `CBR_MODE_TDP) &&
                          (WIDTH_A > `CBR_TDP_MAX_WIDTH ||
                           WIDTH_B > `CBR_TDP_MAX_WIDTH);
    localparam SR_BITS = WIDTH_A * SR_LEN * SR_TAPS;
    localparam SR_WIDE = (WIDTH_A * SR_TAPS > `CBR_SR_MAX_WIDTH);
    localparam SR_BIG  = (SR_BITS > `CBR_MEM_BITS);
    localparam SR_BAD  = (MODE == `CBR_MODE_SHIFT) && (SR_WIDE || SR_BIG);
    localparam PAIR_OK = (G_A == G_B);
    localparam CONF_OK = LEG_A && LEG_B && PAIR_OK && !TDP_WIDE && !SR_BAD &&
                         (WIDTH_A <= `CBR_MAX_WIDTH);

    localparam IS_SP  = (MODE == `CBR_MODE_SP) || (MODE == `CBR_MODE_ROM);
    localparam IS_SDP = (MODE == `CBR_MODE_SDP) || (MODE == `CBR_MODE_FIFO);

    reg [WN-1:0] mem [0:DEPTH-1];

    // Control bits set over the bus, and the config word fixed by parameters
    reg        soft_clr_reg;
    reg        gate_reg;
    reg [31:0] cfg_word;

    wire clr_all = i_clr | soft_clr_reg;
    wire en_a    = gate_reg;
    wire en_b    = gate_reg && !IS_SP;

    // Port strobes; we_a stays low for ROM and shift (shift writes on its own path), only true dual-port writes port B
    wire we_a = en_a && i_wr_en_a && (MODE != `CBR_MODE_ROM) &&
                (MODE != `CBR_MODE_SHIFT);
    wire re_a = en_a && i_rd_en_a && !IS_SDP;
    wire we_b = en_b && i_wr_en_b && (MODE == `CBR_MODE_TDP);
    wire re_b = en_b && i_rd_en_b;

    wire [31:0] wa_a_full = i_addr_a % WA;
    wire [31:0] wa_b_full = i_addr_b % WB;
    wire [12:0] wa_a      = wa_a_full[12:0];
    wire [12:0] wa_b      = wa_b_full[12:0];

    // Collision between two writers and between writer and reader
    localparam RMAX = (RA > RB) ? RA : RB;
    wire [31:0] word_a    = (wa_a * RA) / RMAX;
    wire [31:0] word_b    = (wa_b * RB) / RMAX;
    wire dual_wr   = we_a && we_b && (word_a == word_b);
    wire mixed_hit = we_a && re_b && (word_a == word_b);
    assign o_collision = dual_wr;

    // Read values of the old contents
    reg [WIDTH_A-1:0] old_a;
    reg [WIDTH_B-1:0] old_b;
    integer k;
    always @* begin
        old_a = {WIDTH_A{1'b0}};
        old_b = {WIDTH_B{1'b0}};
        for (k = 0; k < RA; k = k + 1) begin
            old_a[k*WN +: WN] = mem[(wa_a * RA + k) % DEPTH];
        end
        for (k = 0; k < RB; k = k + 1) begin
            old_b[k*WN +: WN] = mem[(wa_b * RB + k) % DEPTH];
        end
    end

    // Shift mode: the taps form one line, each tap SR_LEN deep
    reg  [12:0] sr_ptr_reg;
    wire [12:0] sr_ptr_next = (sr_ptr_reg + 13'h0001 >= SR_LEN[12:0]) ? 13'h0000
                              : sr_ptr_reg + 13'h0001;

    // Memory write, all on the rising edge
    integer j;
    always @(posedge i_ref_clk) begin
        if (MODE == `CBR_MODE_SHIFT) begin
            if (en_a && i_wr_en_a) begin
                for (j = 0; j < SR_TAPS; j = j + 1) begin
                    mem[(j * SR_LEN + sr_ptr_reg) % DEPTH] <= (j == 0) ? i_data_a[WN-1:0]
                        : mem[((j - 1) * SR_LEN + sr_ptr_reg) % DEPTH];
                end
            end
        end else begin
            if (we_a) begin
                for (j = 0; j < RA; j = j + 1) begin
                    mem[(wa_a * RA + j) % DEPTH] <= i_data_a[j*WN +: WN];
                end
            end
            if (we_b) begin
                for (j = 0; j < RB; j = j + 1) begin
                    mem[(wa_b * RB + j) % DEPTH] <= dual_wr ? {WN{1'b0}}
                                                            : i_data_b[j*WN +: WN];
                end
            end
        end
    end

    always @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            sr_ptr_reg <= 13'h0000;
        end else if (MODE == `CBR_MODE_SHIFT && en_a && i_wr_en_a) begin
            sr_ptr_reg <= sr_ptr_next;
        end
    end

    // Port A and port B read data, latched and held between reads; in shift mode port A updates on each shift write instead
    reg  [WIDTH_A-1:0] lat_a_reg;
    reg  [WIDTH_A-1:0] lat_a_next;
    reg  [WIDTH_B-1:0] lat_b_reg;
    reg  [WIDTH_B-1:0] lat_b_next;
    always @* begin
        lat_a_next = lat_a_reg;
        if (MODE == `CBR_MODE_SHIFT) begin
            if (en_a && i_wr_en_a) begin
                lat_a_next = mem[((SR_TAPS - 1) * SR_LEN + sr_ptr_reg) % DEPTH];
            end
        end else if (re_a || (IS_SP && en_a && i_rd_en_a)) begin
            if (we_a && RDW_SAME == `CBR_RDW_NEW) begin
                lat_a_next = i_data_a;
            end else begin
                lat_a_next = old_a;
            end
        end
    end

    always @* begin
        lat_b_next = lat_b_reg;
        if (re_b) begin
            if (we_b && RDW_SAME == `CBR_RDW_NEW) begin
                lat_b_next = i_data_b;
            end else if ((mixed_hit || dual_wr) &&
                         (RDW_MIXED == `CBR_RDW_DONTCARE ||
                          CLK_MODE == `CBR_CLK_RDWR)) begin
                lat_b_next = {WIDTH_B{1'b0}};
            end else begin
                lat_b_next = old_b;
            end
        end
    end

    always @(posedge i_ref_clk) begin
        if (!i_rst_n || clr_all) begin
            lat_a_reg <= {WIDTH_A{1'b0}};
            lat_b_reg <= {WIDTH_B{1'b0}};
        end else begin
            lat_a_reg <= lat_a_next;
            lat_b_reg <= lat_b_next;
        end
    end

    // Optional output register stage
    reg [WIDTH_A-1:0] q_a_reg;
    reg [WIDTH_B-1:0] q_b_reg;
    always @(posedge i_ref_clk) begin
        if (!i_rst_n || clr_all) begin
            q_a_reg <= {WIDTH_A{1'b0}};
            q_b_reg <= {WIDTH_B{1'b0}};
        end else begin
            q_a_reg <= lat_a_reg;
            q_b_reg <= lat_b_reg;
        end
    end

    assign o_q_a = OUT_REG ? q_a_reg : lat_a_reg;
    assign o_q_b = OUT_REG ? q_b_reg : lat_b_reg;

    // AXI4-Lite slave
    reg        aw_got_reg;
    reg        w_got_reg;
    reg [11:0] aw_addr_reg;
    reg [31:0] w_data_reg;
    reg [3:0]  w_strb_reg;
    reg        bvalid_reg;
    reg [1:0]  bresp_reg;
    reg        rvalid_reg;
    reg [31:0] rdata_reg;
    reg [1:0]  rresp_reg;
    reg        coll_seen_reg;

    assign s_axi_awready = !aw_got_reg && !bvalid_reg;
    assign s_axi_wready  = !w_got_reg && !bvalid_reg;
    assign s_axi_bvalid  = bvalid_reg;
    assign s_axi_bresp   = bresp_reg;
    assign s_axi_arready = !rvalid_reg;
    assign s_axi_rvalid  = rvalid_reg;
    assign s_axi_rdata   = rdata_reg;
    assign s_axi_rresp   = rresp_reg;

    wire        aw_now = aw_got_reg || (s_axi_awvalid && s_axi_awready);
    wire        w_now  = w_got_reg  || (s_axi_wvalid && s_axi_wready);
    wire [11:0] aw_use = aw_got_reg ? aw_addr_reg : s_axi_awaddr[11:0];
    wire [31:0] wd_use = w_got_reg ? w_data_reg : s_axi_wdata;
    wire [3:0]  ws_use = w_got_reg ? w_strb_reg : s_axi_wstrb;
    wire        do_wr  = aw_now && w_now && !bvalid_reg;
    wire        coll_clr = do_wr && (aw_use == `CBR_OFF_STATUS) && ws_use[0] && wd_use[0];

    always @* begin
        cfg_word        = 32'h00000000;
        cfg_word[5:0]   = WIDTH_A[5:0];
        cfg_word[7]     = OUT_REG[0];
        cfg_word[9:8]   = RDW_MIXED;
        cfg_word[13:12] = RDW_SAME;
        cfg_word[17:16] = CLK_MODE;
        cfg_word[22:20] = MODE;
    end

    always @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            aw_got_reg   <= 1'b0;
            w_got_reg    <= 1'b0;
            aw_addr_reg  <= 12'h000;
            w_data_reg   <= 32'h00000000;
            w_strb_reg   <= 4'h0;
            bvalid_reg   <= 1'b0;
            bresp_reg    <= `CBR_RESP_OKAY;
            rvalid_reg   <= 1'b0;
            rdata_reg    <= 32'h00000000;
            rresp_reg    <= `CBR_RESP_OKAY;
            soft_clr_reg <= 1'b0;
            gate_reg     <= 1'b1;
            coll_seen_reg <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready && !do_wr) begin
                aw_got_reg  <= 1'b1;
                aw_addr_reg <= s_axi_awaddr[11:0];
            end
            if (s_axi_wvalid && s_axi_wready && !do_wr) begin
                w_got_reg  <= 1'b1;
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
            end
            if (do_wr) begin
                aw_got_reg <= 1'b0;
                w_got_reg  <= 1'b0;
                bvalid_reg <= 1'b1;
                bresp_reg  <= `CBR_RESP_OKAY;
                if (aw_use == `CBR_OFF_CTRL) begin
                    if (ws_use[0]) begin
                        soft_clr_reg <= wd_use[`CBR_CTRL_CLR_BIT];
                        gate_reg     <= wd_use[1];
                    end
                end else if (aw_use != `CBR_OFF_STATUS && aw_use != `CBR_OFF_CONFIG) begin
                    bresp_reg <= `CBR_RESP_SLVERR;
                end
            end else if (bvalid_reg && s_axi_bready) begin
                bvalid_reg <= 1'b0;
            end
            // Sticky write-collision flag, write one to clear, set wins
            if (coll_clr) begin
                coll_seen_reg <= 1'b0;
            end
            if (o_collision) begin
                coll_seen_reg <= 1'b1;
            end
            if (s_axi_arvalid && s_axi_arready) begin
                rvalid_reg <= 1'b1;
                rresp_reg  <= `CBR_RESP_OKAY;
                case (s_axi_araddr[11:0])
                    `CBR_OFF_CTRL: begin
                        rdata_reg <= {30'h00000000, gate_reg, soft_clr_reg};
                    end
                    `CBR_OFF_STATUS: begin
                        rdata_reg <= {30'h00000000, CONF_OK[0], coll_seen_reg};
                    end
                    `CBR_OFF_CONFIG: begin
                        rdata_reg <= cfg_word;
                    end
                    default: begin
                        rdata_reg <= 32'h00000000;
                        rresp_reg <= `CBR_RESP_SLVERR;
                    end
                endcase
            end else if (rvalid_reg && s_axi_rready) begin
                rvalid_reg <= 1'b0;
            end
        end
    end

endmodule

/* cbr_block_ram_properties.sv */
// Port checker for the block RAM: read-during-write, hold, clear, collision.
// Assumes the single-clock 16-bit true dual-port shape, bound from the bench.
`timescale 1ns/1ps
module cbr_block_ram_properties #(
    parameter WIDTH_A = 16,
    parameter WIDTH_B = 16
) (
    input wire               i_ref_clk,
    input wire               i_rst_n,
    input wire               i_clr,
    input wire [12:0]        i_addr_a,
    input wire [WIDTH_A-1:0] i_data_a,
    input wire               i_wr_en_a,
    input wire               i_rd_en_a,
    input wire [WIDTH_A-1:0] o_q_a,
    input wire [12:0]        i_addr_b,
    input wire [WIDTH_B-1:0] i_data_b,
    input wire               i_wr_en_b,
    input wire               i_rd_en_b,
    input wire [WIDTH_B-1:0] o_q_b,
    input wire               o_collision
);
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_n);
    // Depth is 512 words at 16 bits
    wire same_wr = i_wr_en_a && i_wr_en_b && (i_addr_a[8:0] == i_addr_b[8:0]);
    AST_HOLD_A: assert property (!i_rd_en_a && !i_clr |=> $stable(o_q_a))
        else $error("port A output moved without a read");
    AST_HOLD_B: assert property (!i_rd_en_b && !i_clr |=> $stable(o_q_b))
        else $error("port B output moved without a read");
    AST_NEW_A: assert property (i_rd_en_a && i_wr_en_a && !i_clr && !same_wr
        |=> o_q_a == $past(i_data_a)) else $error("port A missed new data");
    AST_NEW_B: assert property (i_rd_en_b && i_wr_en_b && !i_clr && !same_wr
        |=> o_q_b == $past(i_data_b)) else $error("port B missed new data");
    AST_CLR: assert property (i_clr |=> o_q_a == '0 && o_q_b == '0)
        else $error("clear left outputs nonzero");
    AST_PWRUP: assert property (disable iff (1'b0) !i_rst_n |=> o_q_a == '0 && o_q_b == '0)
        else $error("outputs nonzero after reset");
    AST_COLL: assert property (o_collision == same_wr)
        else $error("collision flag wrong");
    AST_RW_B: assert property (i_wr_en_a && !i_wr_en_b && !i_clr ##1 i_rd_en_b &&
        !i_wr_en_b && !i_clr && i_addr_b == $past(i_addr_a) && !same_wr &&
        !(i_wr_en_a && i_addr_a[8:0] == i_addr_b[8:0]) |=> o_q_b == $past(i_data_a, 2))
        else $error("port B missed port A write");
    COV_COLL: cover property (o_collision);
    COV_NEW: cover property (i_rd_en_a && i_wr_en_a);
    COV_CLR: cover property (i_clr ##1 !i_clr);
endmodule

/* cbr_user_port.sv */
// User logic driving one memory port from bench commands.
// Assumes commands come at the rising edge; it drives them one edge later.
`timescale 1ns/1ps
module cbr_user_port #(
    parameter W = 16
) (
    input  wire         i_ref_clk,
    input  wire [31:0]  i_cmd,
    output reg  [12:0]  o_addr,
    output reg  [W-1:0] o_data,
    output reg          o_wr_en,
    output reg          o_rd_en
);
    initial {o_addr, o_data, o_wr_en, o_rd_en} = '0;
    always @(posedge i_ref_clk) begin
        if (i_cmd[31]) begin
            {o_wr_en, o_rd_en, o_addr, o_data} <= i_cmd[30:0]; // Strobes as asked
        end else begin
            // Idle: no strobes, no stale address or data
            {o_wr_en, o_rd_en, o_addr, o_data} <= {2'b00, ~o_addr, ~o_data};
        end
    end
endmodule

/* cbr_block_ram_bench.sv */
// Bench for the block RAM: random and directed port traffic, clear, registers.
// Assumes the 16-bit true dual-port shape on one 200 MHz clock.
`timescale 1ns/1ps
`include "cbr_defines.vh"
`define CHECK(g, e) begin samples_checked++; if ((g) !== (e)) begin fails++; \
    $display("Error t=%0t got=%h exp=%h", $time, (g), (e)); end end
module cbr_block_ram_bench;
    localparam W = 16;
    logic           i_ref_clk = 1'b0, i_rst_n = 1'b0, i_clr = 1'b0, gate = 1'b1;
    logic [31:0]    pa = '0, pb = '0, awaddr = '0, wdata = '0, araddr = '0;
    logic           awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [W-1:0]   mem [0:511];
    logic [W-1:0]   ea = '0, eb = '0, ka, kb;
    int             fails = 0, samples_checked = 0, cycles = 0, seed;
    wire  [12:0]    i_addr_a, i_addr_b;
    wire  [W-1:0]   i_data_a, i_data_b, o_q_a, o_q_b;
    wire            i_wr_en_a, i_rd_en_a, i_wr_en_b, i_rd_en_b, o_collision;
    wire            awready, wready, bvalid, arready, rvalid;
    wire  [1:0]     bresp, rresp;
    wire  [31:0]    rdata;
    cbr_block_ram #(.WIDTH_A(W), .WIDTH_B(W)) i_cbr_block_ram (
        .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_clr(i_clr),
        .i_addr_a(i_addr_a), .i_data_a(i_data_a), .i_wr_en_a(i_wr_en_a),
        .i_rd_en_a(i_rd_en_a), .o_q_a(o_q_a), .i_addr_b(i_addr_b), .i_data_b(i_data_b),
        .i_wr_en_b(i_wr_en_b), .i_rd_en_b(i_rd_en_b), .o_q_b(o_q_b),
        .o_collision(o_collision), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
    cbr_user_port #(.W(W)) i_cbr_user_port_a (.i_ref_clk(i_ref_clk), .i_cmd(pa),
        .o_addr(i_addr_a), .o_data(i_data_a), .o_wr_en(i_wr_en_a), .o_rd_en(i_rd_en_a));
    cbr_user_port #(.W(W)) i_cbr_user_port_b (.i_ref_clk(i_ref_clk), .i_cmd(pb),
        .o_addr(i_addr_b), .o_data(i_data_b), .o_wr_en(i_wr_en_b), .o_rd_en(i_rd_en_b));

    always #2.5 i_ref_clk = ~i_ref_clk;

    function automatic logic [W-1:0] rdw(input logic wr, input logic [W-1:0] d, old);
        rdw = wr ? d : old; // New data on own port, old data across ports
    endfunction

    always @(posedge i_ref_clk) begin
        ka = mem[i_addr_a[8:0]];
        kb = mem[i_addr_b[8:0]];
        if (!i_rst_n || i_clr) {ea, eb} = '0;
        else if (gate) begin
            if (i_rd_en_a) ea = rdw(i_wr_en_a, i_data_a, ka);
            if (i_rd_en_b) eb = rdw(i_wr_en_b, i_data_b, kb);
        end
        if (i_rst_n && gate && i_wr_en_a) mem[i_addr_a[8:0]] = i_data_a;
        if (i_rst_n && gate && i_wr_en_b) // Double write stores zero
            mem[i_addr_b[8:0]] = (i_wr_en_a && i_addr_a[8:0] == i_addr_b[8:0]) ? '0 : i_data_b;
        cycles++;
        if (cycles == 10000) begin
            fails++;
            report_and_stop();
        end
    end

    always @(negedge i_ref_clk) begin
        `CHECK(o_q_a, ea)
        `CHECK(o_q_b, eb)
    end

    task automatic op(input logic wa, ra, input logic [12:0] aa, input logic [W-1:0] da,
                      input logic wb, rb, input logic [12:0] ab, input logic [W-1:0] db);
        @(posedge i_ref_clk);
        pa <= {1'b1, wa, ra, aa, da};
        pb <= {1'b1, wb, rb, ab, db};
    endtask

    task automatic idle();
        @(posedge i_ref_clk);
        {pa, pb} <= '0;
        repeat (2) @(posedge i_ref_clk);
    endtask

    task automatic axi_wr(input logic [31:0] a, d, input logic [1:0] er);
        logic aw, w, b = 1'b0;
        logic [1:0] r;
        @(posedge i_ref_clk);
        {awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'b111};
        while (!b) begin
            @(negedge i_ref_clk);
            {aw, w, b, r} = {awvalid & awready, wvalid & wready, bvalid, bresp};
            @(posedge i_ref_clk);
            {awvalid, wvalid} <= {awvalid & ~aw, wvalid & ~w};
        end
        bready <= 1'b0;
        if (a == 32'(`CBR_OFF_CTRL)) gate = d[1];
        `CHECK(r, er)
    endtask

    task automatic axi_rd(input logic [31:0] a, m, ed, input logic [1:0] er);
        logic ar, v = 1'b0;
        logic [1:0] r;
        logic [31:0] d;
        @(posedge i_ref_clk);
        {araddr, arvalid, rready} <= {a, 2'b11};
        while (!v) begin
            @(negedge i_ref_clk);
            {ar, v, r, d} = {arvalid & arready, rvalid, rresp, rdata};
            @(posedge i_ref_clk);
            arvalid <= arvalid & ~ar;
        end
        rready <= 1'b0;
        `CHECK(r, er)
        `CHECK(d & m, ed)
    endtask

    task automatic report_and_stop();
        $display("Comparisons %0d, mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    initial begin
        logic wa, ra, wb, rb;
        logic [12:0] aa, ab;
        seed = $urandom(70322);
        repeat (10) @(posedge i_ref_clk);
        i_rst_n <= 1'b1;
        for (int i = 0; i < 256; i++) // Both ports write at once
            op(1, 0, 13'(2 * i), W'($urandom), 1, 0, 13'(2 * i + 1), W'($urandom));
        op(1, 1, 13'h0007, 16'h1234, 0, 1, 13'h0007, 16'h0000);
        op(1, 0, 13'h0007, 16'h5678, 0, 0, 13'h0000, 16'h0000);
        op(0, 0, 13'h0000, 16'h0000, 0, 1, 13'h2007, 16'h0000);
        op(1, 0, 13'h0009, 16'hAAAA, 1, 0, 13'h0009, 16'h5555);
        op(0, 1, 13'h0009, 16'h0000, 1, 1, 13'h0009, 16'hC3C3);
        i_clr <= 1'b1;
        op(1, 1, 13'h0003, 16'h0F0F, 0, 1, 13'h0005, 16'h0000);
        op(0, 1, 13'h0003, 16'h0000, 0, 1, 13'h0009, 16'h0000);
        i_clr <= 1'b0;
        for (int i = 0; i < 3000; i++) begin
            {wa, ra, wb, rb} = 4'($urandom);
            aa = $urandom_range(0, 1) ? 13'($urandom_range(0, 15)) : 13'($urandom);
            ab = $urandom_range(0, 1) ? 13'($urandom_range(0, 15)) : 13'($urandom);
            if (wa && wb && aa[8:0] == ab[8:0]) wb = 1'b0;
            op(wa, ra, aa, W'($urandom), wb, rb, ab, W'($urandom));
        end
        idle();
        axi_wr(32'(`CBR_OFF_CTRL), 32'h0, `CBR_RESP_OKAY);
        op(1, 0, 13'h0003, 16'hBEEF, 0, 1, 13'h0004, 16'h0000); // Gated off
        idle();
        axi_wr(32'(`CBR_OFF_CTRL), 32'h2, `CBR_RESP_OKAY);
        op(0, 1, 13'h0003, 16'h0000, 0, 0, 13'h0000, 16'h0000);
        idle();
        axi_rd(32'(`CBR_OFF_CTRL), 32'hFFFFFFFF, 32'h2, `CBR_RESP_OKAY);
        axi_rd(32'(`CBR_OFF_STATUS), 32'h3, 32'h3, `CBR_RESP_OKAY);
        axi_wr(32'(`CBR_OFF_STATUS), 32'h1, `CBR_RESP_OKAY);
        axi_rd(32'(`CBR_OFF_STATUS), 32'h3, 32'h2, `CBR_RESP_OKAY);
        axi_rd(32'h0000000C, 32'hFFFFFFFF, 32'h0, `CBR_RESP_SLVERR);
        axi_wr(32'h00000010, 32'h1, `CBR_RESP_SLVERR);
        report_and_stop();
    end
endmodule

bind cbr_block_ram cbr_block_ram_properties #(.WIDTH_A(WIDTH_A), .WIDTH_B(WIDTH_B)) i_props (
    .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_clr(i_clr), .i_addr_a(i_addr_a),
    .i_data_a(i_data_a), .i_wr_en_a(i_wr_en_a), .i_rd_en_a(i_rd_en_a), .o_q_a(o_q_a),
    .i_addr_b(i_addr_b), .i_data_b(i_data_b), .i_wr_en_b(i_wr_en_b),
    .i_rd_en_b(i_rd_en_b), .o_q_b(o_q_b), .o_collision(o_collision));
